// >>> logic/gsfrf_defs.vh
// Behaviour
// - Sixteen registers; default operand size 32 bits
// - 64-bit size, upper registers need extension prefix
// - Byte, word, dword access everywhere; qword writes in 64-bit mode only
// - Prefix remaps high bytes to pointer lows
// - High byte never paired with new byte
// - 64-bit write updates whole register
// - 32-bit write zeroes upper half in 64-bit mode, keeps it otherwise
// - 8/16-bit writes keep upper bits
// - Upper halves dropped on leaving 64-bit mode
// - Six 16-bit selector registers
// - Code selector refuses data-move loads
// - Fetch address pairs code selector, pointer
// - Stack ops use stack selector; loadable
// - Code, stack, both data bases read zero in 64-bit mode
// - Auxiliary selectors keep their bases
// - Selector loads still run legacy checks
// - Limit checks off in 64-bit mode
// - Status word resets to 00000002H
// - Reserved status bits held fixed
// - Status word moves only in flag groups
// - Task switch saves and reloads status word
// - Handler call pushes status word
// - Wide status word, upper half reserved
`ifndef GSFRF_DEFS_VH
`define GSFRF_DEFS_VH
`define GSFRF_SZ_B        2'h0
`define GSFRF_SZ_W        2'h1
`define GSFRF_SZ_D        2'h2
`define GSFRF_SZ_Q        2'h3
`define GSFRF_SEG_XDATA   3'h0
`define GSFRF_SEG_CS      3'h1
`define GSFRF_SEG_SS      3'h2
`define GSFRF_SEG_DATA    3'h3
`define GSFRF_SEG_AUX1    3'h4
`define GSFRF_SEG_AUX2    3'h5
`define GSFRF_PSW_RESET   32'h00000002
`define GSFRF_ACC_RESET   8'h02
`define GSFRF_PSW_FIX1    32'h00000002
`define GSFRF_PSW_RSVD    32'hFFC0802A
`define GSFRF_PSW_LOWBYTE 32'h000000D5
`define GSFRF_PSW_PUSHMSK 32'h00FC7FD7
`define GSFRF_PSW_FLGMSK  32'h003F7FD5
`define GSFRF_OP_NONE     3'h0
`define GSFRF_OP_FLGLD    3'h1
`define GSFRF_OP_FLGPOP   3'h2
`define GSFRF_OP_TASK     3'h3
`define GSFRF_OP_EXEC     3'h4
`endif

// >>> logic/gsfrf_seg.v
`timescale 1ns/1ps
`default_nettype none
`include "gsfrf_defs.vh"
module gsfrf_seg (
    input  wire        i_mclk,
    input  wire        i_nrst,
    input  wire        i_long_mode,
    input  wire        i_ld_en,
    input  wire [2:0]  i_ld_sel,
    input  wire [15:0] i_ld_val,
    input  wire [63:0] i_ld_base,
    input  wire        i_ld_ctl,
    input  wire [2:0]  i_rd_sel,
    output reg  [15:0] o_sel_ff,
    output reg  [63:0] o_base_ff,
    output reg         o_lim_en_ff,
    output reg         o_cs_rej_ff,
    output reg         o_null_ld_ff,
    output reg  [15:0] o_cs_ff,
    output reg  [15:0] o_ss_ff
);
    reg  [15:0] sel_ff  [0:5];
    reg  [63:0] base_ff [0:5];
    wire        acc_ok;
    integer     k;
    assign acc_ok = i_ld_en && (i_ld_sel <= `GSFRF_SEG_AUX2)
                    && (i_ld_sel != `GSFRF_SEG_CS || i_ld_ctl);
    ////////////////////////////////////////////////////////////////
    always @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            for (k = 0; k < 6; k = k + 1) begin
                sel_ff[k]  <= 16'h0000;
                base_ff[k] <= 64'h0000000000000000;
            end
            o_sel_ff     <= 16'h0000;
            o_base_ff    <= 64'h0000000000000000;
            o_lim_en_ff  <= 1'b1;
            o_cs_rej_ff  <= 1'b0;
            o_null_ld_ff <= 1'b0;
            o_cs_ff      <= 16'h0000;
            o_ss_ff      <= 16'h0000;
        end else begin
            if (acc_ok) begin
                sel_ff[i_ld_sel]  <= i_ld_val;
                base_ff[i_ld_sel] <= i_ld_base;
            end
            o_cs_rej_ff  <= i_ld_en && i_ld_sel == `GSFRF_SEG_CS && !i_ld_ctl;
            // Null stack selector flagged even in 64-bit mode
            o_null_ld_ff <= acc_ok && i_ld_val[15:2] == 14'h0000
                            && (i_ld_sel == `GSFRF_SEG_SS || i_ld_sel == `GSFRF_SEG_CS);
            o_sel_ff     <= (i_rd_sel <= `GSFRF_SEG_AUX2) ? sel_ff[i_rd_sel] : 16'h0000;
            if (i_rd_sel > `GSFRF_SEG_AUX2)
                o_base_ff <= 64'h0000000000000000;
            else if (i_long_mode && i_rd_sel < `GSFRF_SEG_AUX1)
                o_base_ff <= 64'h0000000000000000;
            else
                o_base_ff <= base_ff[i_rd_sel];
            o_lim_en_ff  <= !i_long_mode;
            o_cs_ff      <= sel_ff[`GSFRF_SEG_CS];
            o_ss_ff      <= sel_ff[`GSFRF_SEG_SS];
        end
    end
endmodule // gsfrf_seg
`default_nettype wire

// >>> logic/gsfrf_top.v
`timescale 1ns/1ps
`default_nettype none
`include "gsfrf_defs.vh"
module gsfrf_top (
    input  wire        i_mclk,
    input  wire        i_nrst,
    input  wire        i_warm_rst,
    input  wire        i_long_mode,
    input  wire        i_rex,
    input  wire        i_rex_w,
    input  wire        i_opsz16,
    input  wire        i_wr_en,
    input  wire [3:0]  i_wr_idx,
    input  wire        i_wr_byte,
    input  wire [63:0] i_wr_data,
    input  wire [3:0]  i_ra_idx,
    input  wire [3:0]  i_rb_idx,
    input  wire        i_ra_byte,
    input  wire        i_rb_byte,
    input  wire        i_seg_ld_en,
    input  wire [2:0]  i_seg_ld_sel,
    input  wire [15:0] i_seg_ld_val,
    input  wire [63:0] i_seg_ld_base,
    input  wire        i_seg_ld_ctl,
    input  wire [2:0]  i_seg_rd_sel,
    input  wire [63:0] i_ip,
    input  wire [2:0]  i_psw_op,
    input  wire [31:0] i_psw_data,
    input  wire [31:0] i_psw_exec,
    input  wire [31:0] i_psw_exec_mask,
    input  wire        i_task_save,
    input  wire        i_intr_call,
    output reg  [63:0] o_ra_ff,
    output reg  [63:0] o_rb_ff,
    output reg         o_illegal_ff,
    output reg  [63:0] o_psw_ff,
    output reg  [7:0]  o_accum_flags_ff,
    output reg  [31:0] o_push_word_ff,
    output reg         o_push_valid_ff,
    output reg  [31:0] o_task_word_ff,
    output reg         o_task_valid_ff,
    output reg  [15:0] o_fetch_sel_ff,
    output reg  [63:0] o_fetch_off_ff,
    output reg  [15:0] o_stack_sel_ff,
    output reg  [15:0] o_seg_sel_ff,
    output reg  [63:0] o_seg_base_ff,
    output reg         o_seg_lim_en_ff,
    output reg         o_seg_cs_rej_ff,
    output reg         o_seg_null_ff
);
    ////////////////////////////////////////////////////////////////
    // General-purpose registers
    reg  [63:0] gpr_ff [0:15];
    reg  [31:0] psw_ff;
    reg         long_ff;
    reg         warm_meta_ff;
    reg         warm_sync_ff;
    reg  [1:0]  wsz;
    reg  [3:0]  w_reg;
    reg         w_hi;
    reg  [63:0] nxt_gpr;
    reg         bad;
    wire [15:0] cs_sel;
    wire [15:0] ss_sel;
    wire [15:0] seg_sel;
    wire [63:0] seg_base;
    wire        seg_lim;
    wire        seg_rej;
    wire        seg_null;
    integer     k;

    // Byte index to register and high-byte select
    function [4:0] byte_map;
        input [3:0] idx;
        input       register_extension_prefix;
        begin
            if (!register_extension_prefix && idx[2] && !idx[3])
                byte_map = {2'b00, idx[1:0], 1'b1};
            else
                byte_map = {idx, 1'b0};
        end
    endfunction

    function [63:0] rd_val;
        input [3:0] idx;
        input       bsel;
        input       register_extension_prefix;
        reg   [4:0] m;
        reg   [63:0] v;
        begin
            m = 5'h00;
            v = 64'h0000000000000000;
            if (bsel) begin
                m = byte_map(idx, register_extension_prefix);
                v = gpr_ff[m[4:1]];
                rd_val = m[0] ? {56'h0, v[15:8]} : {56'h0, v[7:0]};
            end else
                rd_val = gpr_ff[idx];
        end
    endfunction

    function is_hi;
        input [3:0] idx;
        input       bsel;
        input       register_extension_prefix;
        reg   [4:0] m;
        begin
            m = byte_map(idx, register_extension_prefix);
            is_hi = bsel && m[0];
        end
    endfunction

    // Prefix gating of size and register reach
    always @* begin
        bad = 1'b0;
        if (i_wr_byte)
            wsz = `GSFRF_SZ_B;
        else if (i_long_mode && i_rex && i_rex_w)
            wsz = `GSFRF_SZ_Q;
        else if (i_opsz16)
            wsz = `GSFRF_SZ_W;
        else
            wsz = `GSFRF_SZ_D;
        if (!i_rex && (i_wr_idx[3] || i_ra_idx[3] || i_rb_idx[3]))
            bad = 1'b1;
        if (!i_long_mode && i_rex)
            bad = 1'b1;
        // High byte beside an upper register operand
        if ((is_hi(i_wr_idx, i_wr_byte, i_rex) || is_hi(i_ra_idx, i_ra_byte, i_rex)
             || is_hi(i_rb_idx, i_rb_byte, i_rex))
            && (i_wr_idx[3] || i_ra_idx[3] || i_rb_idx[3]))
            bad = 1'b1;
    end

    // Write extension policy
    always @* begin
        nxt_gpr = 64'h0000000000000000;
        {w_reg, w_hi} = i_wr_byte ? byte_map(i_wr_idx, i_rex) : {i_wr_idx, 1'b0};
        nxt_gpr = gpr_ff[w_reg];
        case (wsz)
            `GSFRF_SZ_B: begin
                if (w_hi)
                    nxt_gpr[15:8] = i_wr_data[7:0];
                else
                    nxt_gpr[7:0] = i_wr_data[7:0];
            end
            `GSFRF_SZ_W: nxt_gpr[15:0] = i_wr_data[15:0];
            `GSFRF_SZ_D: nxt_gpr = i_long_mode ? {32'h0, i_wr_data[31:0]}
                                            : {nxt_gpr[63:32], i_wr_data[31:0]};
            `GSFRF_SZ_Q: nxt_gpr = i_wr_data;
            default: nxt_gpr = gpr_ff[w_reg];
        endcase
    end

    always @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            for (k = 0; k < 16; k = k + 1) begin
                gpr_ff[k] <= 64'h0000000000000000;
            end
            long_ff      <= 1'b0;
            o_ra_ff      <= 64'h0000000000000000;
            o_rb_ff      <= 64'h0000000000000000;
            o_illegal_ff <= 1'b0;
        end else begin
            long_ff <= i_long_mode;
            if (long_ff && !i_long_mode) begin
                for (k = 0; k < 16; k = k + 1) begin
                    gpr_ff[k][63:32] <= 32'h0;
                end
            end else if (i_wr_en && !bad)
                gpr_ff[w_reg] <= nxt_gpr;
            o_ra_ff      <= rd_val(i_ra_idx, i_ra_byte, i_rex);
            o_rb_ff      <= rd_val(i_rb_idx, i_rb_byte, i_rex);
            o_illegal_ff <= i_wr_en && bad;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Program status word
    // Merge a flag group, reserved bits forced
    function [31:0] psw_merge;
        input [31:0] old;
        input [31:0] val;
        input [31:0] msk;
        begin
            psw_merge = (old & ~msk) | (val & msk & ~`GSFRF_PSW_RSVD)
                        | `GSFRF_PSW_FIX1;
        end
    endfunction

    always @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            psw_ff           <= `GSFRF_PSW_RESET;
            warm_meta_ff     <= 1'b0;
            warm_sync_ff     <= 1'b0;
            o_psw_ff         <= {32'h0, `GSFRF_PSW_RESET};
            o_accum_flags_ff <= `GSFRF_ACC_RESET;
            o_push_word_ff   <= 32'h0;
            o_push_valid_ff  <= 1'b0;
            o_task_word_ff   <= 32'h0;
            o_task_valid_ff  <= 1'b0;
        end else begin
            // Warm restart pin, two-stage synchroniser
            warm_meta_ff <= i_warm_rst;
            warm_sync_ff <= warm_meta_ff;
            if (warm_sync_ff)
                psw_ff <= `GSFRF_PSW_RESET;
            else begin
                case (i_psw_op)
                    `GSFRF_OP_FLGLD: psw_ff <= psw_merge(psw_ff, i_psw_data,
                                                         `GSFRF_PSW_LOWBYTE);
                    `GSFRF_OP_FLGPOP: psw_ff <= psw_merge(psw_ff, i_psw_data,
                                                          `GSFRF_PSW_FLGMSK);
                    `GSFRF_OP_TASK: psw_ff <= psw_merge(psw_ff, i_psw_data,
                                                        ~`GSFRF_PSW_RSVD);
                    `GSFRF_OP_EXEC: psw_ff <= psw_merge(psw_ff, i_psw_exec,
                                                        i_psw_exec_mask);
                    default: psw_ff <= psw_ff;
                endcase
            end
            o_psw_ff         <= {32'h0, psw_ff};
            o_accum_flags_ff <= psw_ff[7:0];
            o_push_valid_ff  <= i_intr_call;
            o_push_word_ff   <= i_intr_call ? psw_ff : o_push_word_ff;
            o_task_valid_ff  <= i_task_save;
            o_task_word_ff   <= i_task_save ? psw_ff : o_task_word_ff;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Segment selectors
    gsfrf_seg u_seg (
        .i_mclk       (i_mclk),
        .i_nrst       (i_nrst),
        .i_long_mode  (i_long_mode),
        .i_ld_en      (i_seg_ld_en),
        .i_ld_sel     (i_seg_ld_sel),
        .i_ld_val     (i_seg_ld_val),
        .i_ld_base    (i_seg_ld_base),
        .i_ld_ctl     (i_seg_ld_ctl),
        .i_rd_sel     (i_seg_rd_sel),
        .o_sel_ff     (seg_sel),
        .o_base_ff    (seg_base),
        .o_lim_en_ff  (seg_lim),
        .o_cs_rej_ff  (seg_rej),
        .o_null_ld_ff (seg_null),
        .o_cs_ff      (cs_sel),
        .o_ss_ff      (ss_sel)
    );

    always @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_fetch_sel_ff  <= 16'h0000;
            o_fetch_off_ff  <= 64'h0000000000000000;
            o_stack_sel_ff  <= 16'h0000;
            o_seg_sel_ff    <= 16'h0000;
            o_seg_base_ff   <= 64'h0000000000000000;
            o_seg_lim_en_ff <= 1'b1;
            o_seg_cs_rej_ff <= 1'b0;
            o_seg_null_ff   <= 1'b0;
        end else begin
            o_fetch_sel_ff  <= cs_sel;
            o_fetch_off_ff  <= i_ip;
            o_stack_sel_ff  <= ss_sel;
            o_seg_sel_ff    <= seg_sel;
            o_seg_base_ff   <= seg_base;
            o_seg_lim_en_ff <= seg_lim;
            o_seg_cs_rej_ff <= seg_rej;
            o_seg_null_ff   <= seg_null;
        end
    end
endmodule // gsfrf_top
`default_nettype wire

// >>> tb/gsfrf_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "gsfrf_defs.vh"
module gsfrf_asserts (
    input wire logic        i_mclk,
    input wire logic        i_nrst,
    input wire logic        i_warm_rst,
    input wire logic        i_long_mode,
    input wire logic        i_rex,
    input wire logic        i_wr_en,
    input wire logic [3:0]  i_wr_idx,
    input wire logic        i_seg_ld_en,
    input wire logic [2:0]  i_seg_ld_sel,
    input wire logic [15:0] i_seg_ld_val,
    input wire logic        i_seg_ld_ctl,
    input wire logic [2:0]  i_seg_rd_sel,
    input wire logic        o_illegal_ff,
    input wire logic [63:0] o_psw_ff,
    input wire logic [15:0] o_fetch_sel_ff,
    input wire logic [63:0] o_seg_base_ff,
    input wire logic        o_seg_lim_en_ff,
    input wire logic        o_seg_cs_rej_ff
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    warm_reset_psw_a: assert property (i_warm_rst [*2] |-> ##3 o_psw_ff == 64'h2)
        else $error("status word not restored by warm reset");
    psw_upper_zero_a: assert property (o_psw_ff[63:32] == 32'h0)
        else $error("wide status word upper half not zero");
    psw_rsvd_fixed_a: assert property ((o_psw_ff[31:0] & `GSFRF_PSW_RSVD) == `GSFRF_PSW_FIX1)
        else $error("reserved status bits not at fixed level");
    limit_check_off_a: assert property ($past(i_nrst, 2) |-> o_seg_lim_en_ff == !$past(i_long_mode, 2))
        else $error("limit check enable wrong for mode");
    cs_load_refused_a: assert property (i_seg_ld_en && i_seg_ld_sel == `GSFRF_SEG_CS && !i_seg_ld_ctl |-> ##2 o_seg_cs_rej_ff)
        else $error("code selector data load not refused");
    fetch_sel_a: assert property (i_seg_ld_en && i_seg_ld_sel == `GSFRF_SEG_CS && i_seg_ld_ctl |-> ##3 o_fetch_sel_ff == $past(i_seg_ld_val, 3))
        else $error("fetch selector not the loaded code selector");
    flat_base_zero_a: assert property (i_long_mode && i_seg_rd_sel < 3'h4 ##1 i_long_mode [*2] |-> o_seg_base_ff == 64'h0)
        else $error("flat segment base not zero in long mode");
    upper_reg_refused_a: assert property (i_wr_en && i_wr_idx[3] && !i_rex |=> o_illegal_ff)
        else $error("upper register write without prefix accepted");
    prefix_refused_a: assert property (i_wr_en && i_rex && !i_long_mode |=> o_illegal_ff)
        else $error("prefixed write outside long mode accepted");
    cover property (i_warm_rst [*2]);
    cover property (o_seg_cs_rej_ff);
    cover property (o_illegal_ff);
endmodule // gsfrf_asserts
bind gsfrf_top gsfrf_asserts u_gsfrf_asserts (.*);
`default_nettype wire

// >>> tb/gsfrf_pipe_model.sv
`timescale 1ns/1ps
`default_nettype none
module gsfrf_pipe_model (
    input  wire logic        i_mclk,
    input  wire logic        i_nrst,
    output var  logic [63:0] o_ip
);
    // Instruction pointer advance by random lengths
    initial o_ip = 64'h0;
    always @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_ip <= 64'h0;
        end else begin
            o_ip <= #1 o_ip + {60'h0, 4'($urandom_range(1, 15))};
        end
    end
endmodule // gsfrf_pipe_model
`default_nettype wire

// >>> tb/test_gpr_segment_flags_regfile.sv
`timescale 1ns/1ps
`default_nettype none
`include "gsfrf_defs.vh"
module test_gpr_segment_flags_regfile;
    logic        i_mclk = '0, i_nrst = '0, i_warm_rst = '0, i_long_mode = '0, i_rex = '0;
    logic        i_rex_w = '0, i_opsz16 = '0, i_wr_en = '0, i_wr_byte = '0, i_ra_byte = '0;
    logic        i_rb_byte = '0, i_seg_ld_en = '0, i_seg_ld_ctl = '0, i_task_save = '0;
    logic        i_intr_call = '0;
    logic [3:0]  i_wr_idx = '0, i_ra_idx = '0, i_rb_idx = '0;
    logic [2:0]  i_seg_ld_sel = '0, i_seg_rd_sel = '0, i_psw_op = '0;
    logic [15:0] i_seg_ld_val = '0;
    logic [63:0] i_wr_data = '0, i_seg_ld_base = '0, ip_q;
    logic [31:0] i_psw_data = '0, i_psw_exec = '0, i_psw_exec_mask = '0;
    wire  [63:0] i_ip, o_ra_ff, o_rb_ff, o_psw_ff, o_fetch_off_ff, o_seg_base_ff;
    wire  [31:0] o_push_word_ff, o_task_word_ff;
    wire  [15:0] o_fetch_sel_ff, o_stack_sel_ff, o_seg_sel_ff;
    wire  [7:0]  o_accum_flags_ff;
    wire         o_illegal_ff, o_push_valid_ff, o_task_valid_ff, o_seg_lim_en_ff;
    wire         o_seg_cs_rej_ff, o_seg_null_ff;
    logic [63:0] gpr [16];
    logic [63:0] sbase [6];
    logic [15:0] ssel [6];
    logic [31:0] psw = 32'h2;
    int          n_fail = 0, compares = 0;

    always #5 i_mclk = ~i_mclk;
    gsfrf_top DUT (.*);
    gsfrf_pipe_model PIPE (.i_mclk(i_mclk), .i_nrst(i_nrst), .o_ip(i_ip));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic step(int n = 1);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    task automatic chk(logic [63:0] got, logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wr(int i, int sz, bit rx, logic [63:0] v);
        bit refuse;
        refuse = !i_long_mode && rx || (i > 7 || i_ra_idx[3] || i_rb_idx[3]) && !rx;
        {i_wr_en, i_wr_idx, i_rex, i_wr_data} = {1'h1, 4'(i), rx, v};
        {i_wr_byte, i_opsz16, i_rex_w} = {sz == 0, sz == 1, sz == 3};
        step();
        chk(o_illegal_ff, refuse);
        if (refuse) return;
        if (sz == 3) gpr[i] = v;
        else if (sz == 2) gpr[i] = {i_long_mode ? 32'h0 : gpr[i][63:32], v[31:0]};
        else if (sz == 1) gpr[i][15:0] = v[15:0];
        else if (!rx && i > 3 && i < 8) gpr[i-4][15:8] = v[7:0];
        else gpr[i][7:0] = v[7:0];
    endtask
    function automatic logic [63:0] rexp(int i, bit bs, bit rx);
        if (!bs) return gpr[i];
        if (!rx && i > 3 && i < 8) return gpr[i-4][15:8];
        return gpr[i][7:0];
    endfunction
    task automatic rd(int a, int b, bit rx, bit ab);
        i_wr_en = '0;
        {i_ra_idx, i_rb_idx, i_rex, i_ra_byte, i_rb_byte} = {4'(a), 4'(b), rx, ab, 1'h1};
        step();
        chk(o_ra_ff, rexp(a, ab, rx));
        chk(o_rb_ff, rexp(b, 1'b1, rx));
    endtask
    task automatic setlm(bit v);
        if (i_long_mode && !v) foreach (gpr[k]) gpr[k][63:32] = 32'h0;
        i_long_mode = v;
        step(2);
    endtask
    task automatic sld(int s, bit c, logic [15:0] v, logic [63:0] b);
        {i_seg_ld_en, i_seg_ld_sel, i_seg_ld_ctl, i_seg_ld_val} = {1'h1, 3'(s), c, v};
        i_seg_ld_base = b;
        step();
        if (s != `GSFRF_SEG_CS || c) {ssel[s], sbase[s]} = {v, b};
    endtask
    task automatic srd(int s);
        i_seg_ld_en = '0;
        i_seg_rd_sel = 3'(s);
        step(2);
        chk(o_seg_sel_ff, ssel[s]);
        chk(o_seg_base_ff, i_long_mode && s < 4 ? 64'h0 : sbase[s]);
        chk(o_fetch_sel_ff, ssel[`GSFRF_SEG_CS]);
        chk(o_stack_sel_ff, ssel[`GSFRF_SEG_SS]);
        chk(o_seg_lim_en_ff, !i_long_mode);
    endtask
    task automatic pop(int op, logic [31:0] v, logic [31:0] m);
        {i_psw_op, i_psw_data, i_psw_exec, i_psw_exec_mask} = {3'(op), v, v, m};
        step();
        i_psw_op = `GSFRF_OP_NONE;
        if (op == `GSFRF_OP_FLGLD) m = `GSFRF_PSW_LOWBYTE;
        if (op == `GSFRF_OP_FLGPOP) m = `GSFRF_PSW_FLGMSK;
        if (op == `GSFRF_OP_TASK) m = ~`GSFRF_PSW_RSVD;
        psw = (psw & ~m | v & m) & ~`GSFRF_PSW_RSVD | `GSFRF_PSW_FIX1;
        step(2);
        chk(o_psw_ff, {32'h0, psw});
        chk(o_accum_flags_ff, psw[7:0]);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int i, sz, b;
        bit rx;
        void'($urandom(32'hB951));
        step(12);
        chk(o_psw_ff, 64'h2);
        chk(o_seg_lim_en_ff, 1);
        i_nrst = '1;
        setlm(1);
        for (int k = 0; k < 16; k++) wr(k, 3, 1, {$urandom, $urandom});
        repeat (150) begin
            i = $urandom_range(0, 15);
            sz = $urandom_range(0, 3);
            rx = i > 7 || sz == 3 || $urandom_range(0, 1);
            b = $urandom_range(0, 15);
            wr(i, sz, rx, {$urandom, $urandom});
            rd(i, b, rx || b > 7, 1'($urandom_range(0, 1)));
        end
        wr(9, 2, 0, 64'hFFFFFFFFFFFFFFFF);
        chk(o_illegal_ff, 1);
        rd(9, 12, 1, 0);
        setlm(0);
        wr(1, 2, 1, 64'hFFFFFFFFFFFFFFFF);
        chk(o_illegal_ff, 1);
        for (int k = 0; k < 8; k++) rd(k, k, 0, 0);
        for (int m = 0; m < 2; m++) begin
            setlm(m[0]);
            for (int s = 0; s < 6; s++) sld(s, 1, 16'($urandom) | 16'h8, {$urandom, $urandom});
            for (int s = 0; s < 6; s++) srd(s);
        end
        sld(1, 0, 16'h1234, 64'h0);
        i_seg_ld_en = '0;
        step();
        chk(o_seg_cs_rej_ff, 1);
        srd(1);
        sld(2, 1, 16'h3, 64'h0);
        i_seg_ld_en = '0;
        step();
        chk(o_seg_null_ff, 1);
        @(posedge i_mclk) ip_q = i_ip;
        #1 chk(o_fetch_off_ff, ip_q);
        for (int k = 0; k < 20; k++) pop(k % 4 + 1, $urandom, $urandom);
        i_intr_call = '1;
        step();
        i_intr_call = '0;
        chk({o_push_valid_ff, o_push_word_ff}, {1'h1, psw});
        i_task_save = '1;
        step();
        i_task_save = '0;
        chk({o_push_valid_ff, o_task_valid_ff, o_task_word_ff}, {2'h1, psw});
        {i_warm_rst, i_psw_op, i_psw_data} = {1'h1, `GSFRF_OP_FLGPOP, 32'hFFFFFFFF};
        step(4);
        {i_warm_rst, i_psw_op} = 4'h0;
        step();
        chk(o_psw_ff, 64'h2);
        print_verdict();
    end
    initial begin
        #500000;
        n_fail++;
        print_verdict();
    end
endmodule // test_gpr_segment_flags_regfile
`default_nettype wire
